// ===== logic/search_pkg.sv
//==============================================================
// Purpose: Constants and types for the block pattern search engine.
// Assumes: 512-byte logical blocks; APB register access.
// Notes: Summary of operation is listed below.
//==============================================================
// Summary of operation
// - Rezero returns unit to fixed state.
// - Opcodes 31h/30h/32h select equal/high/low.
// - Unspanned records skip short block tails.
// - Spanned records cross block boundaries.
// - Zero block count searches nothing, no error.
// - Unlinked: condition met or good.
// - Linked match: intermediate condition met.
// - Linked miss: check condition.
// - Relative next address adds match block.
// - Sense key equal or no sense.
// - Valid set, block and offset reported.
// - Miss: no sense, valid cleared.
// - Fourteen-byte big-endian parameter header.
// - Record length counts bytes.
// - Offset skips first block; too large fails.
// - Later blocks scanned from byte zero.
// - Stop on match, record or block limit.
// - Walk descriptors one by one.
// - Descriptor: displacement, length, pattern.
// - Compare from record start plus displacement.
// - All descriptors must hold; first wins.
// - Equal variant with invert.
// - High variant with invert.
// - Low variant with invert.
package search_pkg;
	localparam int BLK_SHIFT = 9;
	localparam logic [32:0] BLK_BYTES = 33'h000000200;
	localparam logic [7:0] OP_REZERO = 8'h01;
	localparam logic [7:0] OP_HIGH = 8'h30;
	localparam logic [7:0] OP_EQUAL = 8'h31;
	localparam logic [7:0] OP_LOW = 8'h32;
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [7:0] ST_MET = 8'h04;
	localparam logic [7:0] ST_IMET = 8'h14;
	localparam logic [3:0] SK_NONE = 4'h0;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [3:0] SK_EQUAL = 4'hC;
	localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
	localparam logic [7:0] ASC_BAD_OP = 8'h20;
	localparam int INV_BIT = 4;
	localparam int SPAN_BIT = 1;
	localparam int REL_BIT = 0;
	localparam int LINK_BIT = 0;
	localparam logic [5:0] HDR_RL = 6'h00;
	localparam logic [5:0] HDR_OFF = 6'h04;
	localparam logic [5:0] HDR_NREC = 6'h08;
	localparam logic [5:0] HDR_ALEN = 6'h0C;
	localparam logic [16:0] HDR_BYTES = 17'h0000E;
	localparam logic [16:0] D_PLEN = 17'h00004;
	localparam logic [16:0] D_PAT = 17'h00006;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CDB0 = 8'h04;
	localparam logic [7:0] A_CDB1 = 8'h08;
	localparam logic [7:0] A_CDB2 = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_SENSE = 8'h14;
	localparam logic [7:0] A_INFO = 8'h18;
	localparam logic [7:0] A_CSI = 8'h1C;
	localparam logic [7:0] A_NLBA = 8'h20;
	localparam logic [7:0] A_NCTL = 8'h24;
	localparam logic [7:0] A_ELBA = 8'h28;
	localparam logic [7:0] A_CUR = 8'h2C;
	localparam logic [7:0] A_PARAM = 8'h40;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	typedef struct packed {
		logic [31:0] lba;
		logic [8:0] idx;
	} med_req_t;
	typedef enum logic [1:0] {REL_EQ = 2'b00, REL_GT = 2'b01, REL_LT = 2'b10} rel_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_SETUP = 3'b001, S_REC = 3'b011, S_DESC = 3'b010,
		S_FETCH = 3'b110, S_CMPB = 3'b111, S_NEXTD = 3'b101, S_DONE = 3'b100
	} state_t;
endpackage : search_pkg

// ===== logic/search_engine.sv
//==============================================================
// Purpose: Rezero and pattern search command engine, APB slave.
// Assumes: Media byte reads answered by med_ack with med_data.
// Notes: CDB and parameter writes are ignored while busy.
//==============================================================
`timescale 1ns/1ps
`default_nettype none
module search_engine (
	input wire logic pclk, // Bus clock, 40 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // Slave select.
	input wire logic penable, // Access phase.
	input wire logic pwrite, // Write direction.
	input wire logic [7:0] paddr, // Byte address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic [3:0] pstrb, // Write byte lanes.
	output logic [31:0] prdata, // Read data.
	output logic pready, // Transfer done.
	output logic pslverr, // Unmapped address.
	output logic med_req, // Media byte request.
	output search_pkg::med_req_t med_addr, // Block and byte index.
	input wire logic med_ack, // Media byte valid.
	input wire logic [7:0] med_data // Media byte.
);
	import search_pkg::*;

	//==========================================================
	// Storage and state
	logic [31:0] cdb_q [3];
	logic [7:0] pm_q [64];
	state_t state_q;
	logic pready_q, pslverr_q, busy_q, res_q, start_q, med_req_q;
	logic [31:0] prdata_q, rec_q, cnt_q, disp_q, info_q, csi_q;
	logic [31:0] cur_q, nlba_q;
	logic [16:0] dptr_q;
	logic [15:0] plen_q, bi_q;
	rel_t rel_q;
	logic [7:0] status_q, asc_q;
	logic [3:0] skey_q;
	logic sv_q, relative_address_flag_q;
	med_req_t med_addr_q;

	// Gather a big-endian word from the parameter area.
	function automatic logic [31:0] get32(input logic [5:0] p);
		logic [5:0] i;
		i = p;
		get32 = {pm_q[i], pm_q[i + 6'd1], pm_q[i + 6'd2], pm_q[i + 6'd3]};
	endfunction : get32

	// Whether one descriptor's comparison holds.
	function automatic logic holds(input logic [7:0] op, input logic inv,
			input rel_t r);
		logic h;
		h = (op == OP_EQUAL) ? (r == REL_EQ) :
			(op == OP_HIGH) ? (r == REL_GT) : (r == REL_LT);
		holds = h ^ inv;
	endfunction : holds

	// Register word returned for a read address.
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [5:0] b;
		b = {a[5:2], 2'b00};
		rd_mux = RST_WORD;
		if (a >= A_PARAM)
			rd_mux = {pm_q[b], pm_q[b + 6'd1], pm_q[b + 6'd2], pm_q[b + 6'd3]};
		else
			unique case (a)
				A_CDB0: rd_mux = cdb_q[0];
				A_CDB1: rd_mux = cdb_q[1];
				A_CDB2: rd_mux = cdb_q[2];
				A_STAT: rd_mux = {23'h0, busy_q, status_q};
				A_SENSE: rd_mux = {sv_q, 15'h0, asc_q, 4'h0, skey_q};
				A_INFO: rd_mux = info_q;
				A_CSI: rd_mux = csi_q;
				A_NLBA: rd_mux = nlba_q;
				A_NCTL: rd_mux = {31'h0, relative_address_flag_q};
				A_ELBA: rd_mux = relative_address_flag_q ? info_q + nlba_q : nlba_q;
				A_CUR: rd_mux = cur_q;
				default: rd_mux = RST_WORD;
			endcase
	endfunction : rd_mux

	//==========================================================
	// Bus decode
	wire acc = psel && penable && pready_q;
	// A write lands only at the completing edge and only on a mapped word,
	// so an unaligned or unmapped address never disturbs a register.
	wire wr = acc && pwrite && mapped;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= A_CUR || paddr >= A_PARAM);
	wire wr_cdb = wr && !busy_q && (paddr >= A_CDB0) && (paddr <= A_CDB2);
	wire wr_pm = wr && !busy_q && (paddr >= A_PARAM);
	wire go = wr && !busy_q && (paddr == A_CTRL) && pwdata[0];

	//==========================================================
	// Command and header fields
	wire [7:0] op = cdb_q[0][31:24];
	wire [7:0] b1 = cdb_q[0][23:16];
	wire [31:0] lba = {cdb_q[0][15:0], cdb_q[1][31:16]};
	wire [15:0] nblk = {cdb_q[1][7:0], cdb_q[2][31:24]};
	wire link = cdb_q[2][16 + LINK_BIT];
	wire inv = b1[INV_BIT];
	// Spanned records may cross block ends; unspanned ones skip short tails.
	wire records_span_blocks = b1[SPAN_BIT];
	wire is_srch = (op == OP_EQUAL) || (op == OP_HIGH) || (op == OP_LOW);
	wire [31:0] rl = get32(HDR_RL);
	wire [31:0] fro = get32(HDR_OFF);
	wire [31:0] nrec = get32(HDR_NREC);
	wire [16:0] dend = HDR_BYTES + {1'b0, pm_q[HDR_ALEN], pm_q[HDR_ALEN + 6'd1]};
	wire [32:0] limit = {8'h00, nblk, 9'h000};
	wire [32:0] rec_end = {1'b0, rec_q} + {1'b0, rl};
	wire fit_lim = rec_end <= limit;
	wire fit_blk = ({24'h000000, rec_q[8:0]} + {1'b0, rl}) <= BLK_BYTES;
	wire [31:0] byte_a = rec_q + disp_q + {16'h0000, bi_q};
	wire [7:0] pat = pm_q[6'(dptr_q + D_PAT + {1'b0, bi_q})];
	wire pm_end = dptr_q >= dend;
	wire desc_ok = holds(op, inv, rel_q);

	//==========================================================
	// Bus slave: one wait state, read data sampled in that cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= RST_WORD;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
			prdata_q <= rd_mux(paddr);
		end
	end

	// Software-written command and link registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++)
				cdb_q[i] <= RST_WORD;
			nlba_q <= RST_WORD;
			relative_address_flag_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			start_q <= go;
			if (wr_cdb)
				cdb_q[paddr[3:2] - 2'd1] <= pwdata;
			if (wr && paddr == A_NLBA)
				nlba_q <= pwdata;
			if (wr && paddr == A_NCTL)
				relative_address_flag_q <= pwdata[REL_BIT];
		end
	end

	// Parameter list bytes, most significant lane first.
	always_ff @(posedge pclk) begin
		for (int b = 0; b < 4; b++)
			if (wr_pm && pstrb[3 - b])
				pm_q[{paddr[5:2], 2'(b)}] <= pwdata[8 * (3 - b) +: 8];
	end

	//==========================================================
	// Search engine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			busy_q <= 1'b0;
			res_q <= 1'b0;
			rec_q <= RST_WORD;
			cnt_q <= RST_WORD;
			disp_q <= RST_WORD;
			dptr_q <= 17'h00000;
			plen_q <= 16'h0000;
			bi_q <= 16'h0000;
			rel_q <= REL_EQ;
			status_q <= ST_GOOD;
			skey_q <= SK_NONE;
			asc_q <= 8'h00;
			sv_q <= 1'b0;
			info_q <= RST_WORD;
			csi_q <= RST_WORD;
			cur_q <= RST_WORD;
			med_req_q <= 1'b0;
			med_addr_q <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (start_q) begin
						busy_q <= 1'b1;
						state_q <= S_SETUP;
					end
				end
				S_SETUP: begin
					res_q <= 1'b0;
					rec_q <= fro;
					cnt_q <= RST_WORD;
					state_q <= S_DONE;
					asc_q <= 8'h00;
					skey_q <= SK_NONE;
					sv_q <= 1'b0;
					status_q <= ST_GOOD;
					if (op == OP_REZERO)
						cur_q <= RST_WORD;
					else if (!is_srch) begin
						status_q <= ST_CHECK;
						skey_q <= SK_ILLEGAL;
						asc_q <= ASC_BAD_OP;
					end else if (nblk == 16'h0000)
						status_q <= ST_GOOD;
					else if ({1'b0, fro} > BLK_BYTES) begin
						status_q <= ST_CHECK;
						skey_q <= SK_ILLEGAL;
						asc_q <= ASC_BAD_PARAM;
					end else
						state_q <= S_REC;
				end
				S_REC: begin
					dptr_q <= HDR_BYTES;
					if (cnt_q == nrec || !fit_lim)
						state_q <= S_DONE;
					else if (!records_span_blocks && !fit_blk)
						rec_q <= {rec_q[31:9] + 23'd1, 9'h000};
					else
						state_q <= S_DESC;
				end
				S_DESC: begin
					if (pm_end) begin
						res_q <= 1'b1;
						state_q <= S_DONE;
					end else begin
						disp_q <= get32(dptr_q[5:0]);
						plen_q <= {pm_q[6'(dptr_q + D_PLEN)],
							pm_q[6'(dptr_q + D_PLEN + 17'd1)]};
						bi_q <= 16'h0000;
						rel_q <= REL_EQ;
						state_q <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (bi_q == plen_q)
						state_q <= S_NEXTD;
					else begin
						med_req_q <= 1'b1;
						med_addr_q.lba <= lba + {9'h000, byte_a[31:BLK_SHIFT]};
						med_addr_q.idx <= byte_a[8:0];
						state_q <= S_CMPB;
					end
				end
				S_CMPB: begin
					if (med_ack) begin
						med_req_q <= 1'b0;
						state_q <= S_FETCH;
						if (med_data != pat) begin
							rel_q <= (med_data > pat) ? REL_GT : REL_LT;
							bi_q <= plen_q;
						end else
							bi_q <= bi_q + 16'd1;
					end
				end
				S_NEXTD: begin
					if (desc_ok) begin
						dptr_q <= dptr_q + D_PAT + {1'b0, plen_q};
						state_q <= S_DESC;
					end else begin
						rec_q <= rec_end[31:0];
						cnt_q <= cnt_q + 32'd1;
						state_q <= S_REC;
					end
				end
				S_DONE: begin
					busy_q <= 1'b0;
					state_q <= S_IDLE;
					if (is_srch && nblk != 16'h0000 && status_q == ST_GOOD) begin
						sv_q <= res_q;
						if (res_q) begin
							status_q <= link ? ST_IMET : ST_MET;
							skey_q <= (op == OP_EQUAL && !inv) ? SK_EQUAL : SK_NONE;
							info_q <= lba + {9'h000, rec_q[31:BLK_SHIFT]};
							csi_q <= {23'h000000, rec_q[8:0]};
							cur_q <= lba + {9'h000, rec_q[31:BLK_SHIFT]};
						end else begin
							status_q <= link ? ST_CHECK : ST_GOOD;
							skey_q <= SK_NONE;
						end
					end
				end
			endcase
		end
	end

	//==========================================================
	// Outputs straight from flip-flops.
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign med_req = med_req_q;
	assign med_addr = med_addr_q;

	//==========================================================
	// Checks.
	chk_rezero_done: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_SETUP && op == OP_REZERO) |=> ##1 (status_q == ST_GOOD && !busy_q
		&& cur_q == RST_WORD))
		else $error("rezero did not end good");
	chk_zero_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_SETUP && is_srch && nblk == 16'h0000) |=> ##1
		(status_q == ST_GOOD && !sv_q && !busy_q))
		else $error("zero block search not good");
	chk_offset_check: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_SETUP && is_srch && nblk != 16'h0000 && {1'b0, fro} > BLK_BYTES)
		|=> ##1 (status_q == ST_CHECK && skey_q == SK_ILLEGAL && asc_q == ASC_BAD_PARAM))
		else $error("oversize offset not rejected");
	chk_unlinked_met: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && res_q && !link && is_srch) |=> (status_q == ST_MET && sv_q))
		else $error("unlinked match status wrong");
	chk_linked_met: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && res_q && link && is_srch) |=> (status_q == ST_IMET))
		else $error("linked match status wrong");
	chk_linked_miss: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && !res_q && link && is_srch && nblk != 16'h0000
		&& status_q == ST_GOOD) |=> (status_q == ST_CHECK && !sv_q && skey_q == SK_NONE))
		else $error("linked miss not check");
	chk_equal_key: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && res_q && is_srch && status_q == ST_GOOD) |=>
		(skey_q == ((op == OP_EQUAL && !inv) ? SK_EQUAL : SK_NONE)
		&& csi_q[8:0] == $past(rec_q[8:0])))
		else $error("match sense wrong");
	chk_tail_skip: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_REC && cnt_q != nrec && fit_lim && !records_span_blocks && !fit_blk)
		|=> (rec_q[8:0] == 9'h000 && state_q == S_REC))
		else $error("short tail not skipped");
	chk_media_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(med_req_q && !med_ack) |=> (med_req_q && $stable(med_addr_q)))
		else $error("media request dropped");
	// Scan sequencing: where each step of the record walk must lead.
	chk_offset_start: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_SETUP && is_srch && nblk != 16'h0000 && {1'b0, fro} <= BLK_BYTES)
		|=> (state_q == S_REC && rec_q == fro))
		else $error("first record offset not applied");
	chk_record_limit: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_REC && (cnt_q == nrec || !fit_lim)) |=> (state_q == S_DONE))
		else $error("scan ran past its limit");
	chk_span_enter: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_REC && records_span_blocks && cnt_q != nrec && fit_lim)
		|=> (state_q == S_DESC))
		else $error("spanned record not searched");
	chk_all_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DESC && pm_end) |=> (res_q && state_q == S_DONE))
		else $error("full match not taken");
	chk_miss_advance: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_NEXTD && !desc_ok) |=> (state_q == S_REC
		&& rec_q == $past(rec_q) + $past(rl) && cnt_q == $past(cnt_q) + 32'd1))
		else $error("next record not one length on");
	// Media side: the byte fetched is record start plus displacement plus index.
	chk_fetch_addr: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_FETCH && bi_q != plen_q) |=> (med_req_q
		&& {med_addr_q.lba - lba, med_addr_q.idx} == {9'h000, $past(byte_a)}))
		else $error("media address wrong");
	chk_media_release: assert property (@(posedge pclk) disable iff (!presetn)
		(med_req_q && med_ack) |=> !med_req_q)
		else $error("media request held after answer");
	chk_compare_rank: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_CMPB && med_ack && med_data != pat) |=> (bi_q == plen_q
		&& ((rel_q == REL_GT) == ($past(med_data) > $past(pat)))))
		else $error("byte order not unsigned");
	// Sense results after a completed search.
	chk_match_info: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && res_q && is_srch && status_q == ST_GOOD)
		|=> (sv_q && info_q == lba + {9'h000, $past(rec_q[31:BLK_SHIFT])}))
		else $error("match block not reported");
	chk_miss_sense: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == S_DONE && !res_q && is_srch && nblk != 16'h0000
		&& status_q == ST_GOOD) |=> (!sv_q && skey_q == SK_NONE))
		else $error("unmatched search sense wrong");
endmodule : search_engine
`default_nettype wire

// ===== bench/media_model.sv
// Purpose: Medium model answering byte requests of the engine.
// Assumes: One byte outstanding; ack is a one-cycle pulse.
// Notes: Byte value is index xor low byte of block address.
`timescale 1ns/1ps
`default_nettype none
module media_model (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic slow, // Adds two wait cycles per byte.
	input wire logic med_req, // Byte request.
	input wire search_pkg::med_req_t med_addr, // Block and index.
	output logic med_ack, // Byte valid pulse.
	output logic [7:0] med_data // Byte, scrambled when not valid.
);
	import search_pkg::*;
	logic [2:0] wait_q;
	// Answer after the wait; between answers the data toggles so it is never trusted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 3'h0;
			med_ack <= 1'b0;
			med_data <= 8'h00;
		end else if (med_req && !med_ack && wait_q >= {1'b0, slow, 1'b0}) begin
			wait_q <= 3'h0;
			med_ack <= 1'b1;
			med_data <= med_addr.idx[7:0] ^ med_addr.lba[7:0];
		end else begin
			wait_q <= (med_req && !med_ack) ? wait_q + 3'h1 : 3'h0;
			med_ack <= 1'b0;
			med_data <= ~med_data;
		end
	end
endmodule : media_model
`default_nettype wire

// ===== bench/search_engine_bench.sv
// Purpose: Self-checking bench of the search engine.
// Assumes: Medium byte equals index xor low block byte.
// Notes: Expected positions are worked out from that pattern.
`timescale 1ns/1ps
`default_nettype none
module search_engine_bench;
	import search_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic er;
	logic med_req;
	logic med_ack;
	logic [7:0] med_data;
	med_req_t med_addr;
	logic [7:0] pb [64] = '{default: 8'h00};
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	search_engine i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .med_req(med_req), .med_addr(med_addr),
		.med_ack(med_ack), .med_data(med_data));
	media_model i_med (.pclk(pclk), .presetn(presetn), .slow(slow), .med_req(med_req),
		.med_addr(med_addr), .med_ack(med_ack), .med_data(med_data));
	//==============================================================
	// Clock, timeout and helpers
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	// A hang counts as a mismatch and closes the run.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("Counts: %0d checked, %0d errors", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic hdr(input logic [31:0] rl, off, nr, input logic [15:0] al);
		{pb[0], pb[1], pb[2], pb[3]} = rl;
		{pb[4], pb[5], pb[6], pb[7]} = off;
		{pb[8], pb[9], pb[10], pb[11]} = nr;
		{pb[12], pb[13]} = al;
	endtask : hdr
	// One-byte descriptor at offset 14.
	task automatic dsc1(input logic [31:0] disp, input logic [7:0] pat);
		{pb[14], pb[15], pb[16], pb[17], pb[18], pb[19], pb[20]} = {disp, 16'h0001, pat};
	endtask : dsc1
	// Loads parameters and command, starts it and waits until not busy.
	task automatic cmd(input logic [7:0] op, fl, input logic [31:0] lba,
			input logic [15:0] nb, input logic [7:0] ctl);
		for (int k = 0; k < 16; k++)
			apb(1'b1, A_PARAM + 8'(4 * k), {pb[4 * k], pb[4 * k + 1], pb[4 * k + 2], pb[4 * k + 3]});
		apb(1'b1, A_CDB0, {op, fl, lba[31:16]});
		apb(1'b1, A_CDB1, {lba[15:0], 8'h00, nb[15:8]});
		apb(1'b1, A_CDB2, {nb[7:0], ctl, 16'h0000});
		apb(1'b1, A_CTRL, 32'h00000001);
		do apb(1'b0, A_STAT, 32'h0); while (rd[8] !== 1'b0);
	endtask : cmd
	// Checks status, sense word and, when valid, block and offset.
	task automatic res(input logic [7:0] st, input logic [31:0] sn, info, csi);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd, {24'h0, st});
		apb(1'b0, A_SENSE, 32'h0);
		chk(rd, sn);
		if (sn[31]) begin
			apb(1'b0, A_INFO, 32'h0);
			chk(rd, info);
			apb(1'b0, A_CSI, 32'h0);
			chk(rd, csi);
		end
	endtask : res
	//==============================================================
	// Scenarios
	task automatic t_equal();
		hdr(32'h10, 32'h0, 32'h3, 16'h7);
		dsc1(32'h2, 8'h37);
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h1, 8'h00);
		res(ST_GOOD, 32'h0, 32'h0, 32'h0);
		pb[11] = 8'h04;
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h1, 8'h00);
		res(ST_MET, 32'h8000000C, 32'h5, 32'h30);
		cmd(OP_EQUAL, 8'h10, 32'h5, 16'h1, 8'h00);
		res(ST_MET, 32'h80000000, 32'h5, 32'h0);
		pb[11] = 8'h03;
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h1, 8'h01);
		res(ST_CHECK, 32'h0, 32'h0, 32'h0);
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h0, 8'h00);
		res(ST_GOOD, 32'h0, 32'h0, 32'h0);
		$display("test equal done");
	endtask : t_equal
	task automatic t_order();
		slow <= 1'b1;
		hdr(32'h10, 32'h0, 32'h100, 16'h7);
		dsc1(32'hF, 8'hFE);
		cmd(OP_HIGH, 8'h00, 32'h0, 16'h1, 8'h00);
		res(ST_MET, 32'h80000000, 32'h0, 32'hF0);
		dsc1(32'h0, 8'h03);
		apb(1'b1, A_NLBA, 32'h7);
		apb(1'b1, A_NCTL, 32'h1);
		cmd(OP_LOW, 8'h00, 32'h2, 16'h1, 8'h01);
		res(ST_IMET, 32'h80000000, 32'h2, 32'h0);
		apb(1'b0, A_ELBA, 32'h0);
		chk(rd, 32'h9);
		slow <= 1'b0;
		$display("test ordered done");
	endtask : t_order
	task automatic t_offset();
		hdr(32'h10, 32'h3, 32'h100, 16'h7);
		dsc1(32'h2, 8'h20);
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h1, 8'h00);
		res(ST_MET, 32'h8000000C, 32'h5, 32'h23);
		pb[6] = 8'h02;
		pb[7] = 8'h01;
		cmd(OP_EQUAL, 8'h00, 32'h5, 16'h1, 8'h00);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd, {24'h0, ST_CHECK});
		apb(1'b0, A_SENSE, 32'h0);
		chk({16'h0, rd[15:0]}, {16'h0, ASC_BAD_PARAM, 4'h0, SK_ILLEGAL});
		$display("test offset done");
	endtask : t_offset
	task automatic t_span();
		hdr(32'h12C, 32'h0, 32'h100, 16'h7);
		dsc1(32'hFA, 8'h27);
		cmd(OP_EQUAL, 8'h02, 32'h0, 16'h2, 8'h00);
		res(ST_MET, 32'h8000000C, 32'h0, 32'h12C);
		cmd(OP_EQUAL, 8'h00, 32'h0, 16'h2, 8'h00);
		res(ST_GOOD, 32'h0, 32'h0, 32'h0);
		pb[20] = 8'hFB;
		cmd(OP_EQUAL, 8'h00, 32'h0, 16'h2, 8'h00);
		res(ST_MET, 32'h8000000C, 32'h1, 32'h0);
		$display("test span done");
	endtask : t_span
	task automatic t_multi();
		hdr(32'h10, 32'h0, 32'h100, 16'hF);
		{pb[14], pb[15], pb[16], pb[17], pb[18], pb[19], pb[20], pb[21]} = 64'h0000000000025051;
		{pb[22], pb[23], pb[24], pb[25], pb[26], pb[27], pb[28]} = 56'h00000005000155;
		cmd(OP_EQUAL, 8'h00, 32'h0, 16'h1, 8'h00);
		res(ST_MET, 32'h8000000C, 32'h0, 32'h50);
		pb[28] = 8'h45;
		cmd(OP_EQUAL, 8'h00, 32'h0, 16'h1, 8'h00);
		res(ST_GOOD, 32'h0, 32'h0, 32'h0);
		$display("test multi done");
	endtask : t_multi
	task automatic t_misc();
		apb(1'b0, A_CUR, 32'h0);
		chk(rd, 32'h1);
		cmd(OP_REZERO, 8'h00, 32'h0, 16'h0, 8'h00);
		apb(1'b0, A_CUR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd, {24'h0, ST_GOOD});
		apb(1'b0, 8'h30, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test misc done");
	endtask : t_misc
	//==============================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_equal();
		t_order();
		t_offset();
		t_multi();
		t_span();
		t_misc();
		report_and_stop();
	end
endmodule : search_engine_bench
`default_nettype wire
